// ==== verilog/usbpes_pkg.sv ====
//=============================================================
// Purpose: constants for the USB peripheral event status block
// Assumes: two device instances, eight endpoints, 16-bit registers
// Notes:   instance 0 sits on the otg_capable_port
//=============================================================
// Functional notes
// - with ID interrupt enabled, both edges of the OTG ID pin set bit 14.
// - ID flag exists only in instance one; instance two reads bit 14 as zero.
// - SOF/EOP received sets status bit 9.
// - detected USB bus reset sets status bit 8.
// - endpoint 0..7 transaction end sets the flag at its endpoint number.
// - with per-endpoint NAK enable, a NAK answer also sets that endpoint flag.
// - each flag reads 1 once its event fired, 0 otherwise.
// - one read-only frame register per instance; writes to it do nothing.
// - writing one clears a status flag; writing zero leaves it.
// - full-speed SOF loads frame bits 10:0; value held across timeouts.
// - enabled timeout steps 3-bit counter 0 to 7; SOF/EOP returns it to zero.
package usbpes_pkg;
   localparam int NUM_DEV = 2;
   localparam int NUM_EP = 8;
   localparam int FRAME_W = 11;
   localparam logic [1:0][15:0] ADDR_STATUS = {16'hC0B0, 16'hC090};
   localparam logic [1:0][15:0] ADDR_FRAME = {16'hC0B2, 16'hC092};
   localparam int BIT_ID = 14;
   localparam int BIT_SOF = 9;
   localparam int BIT_RST = 8;
   localparam int BIT_TO_FLAG = 15;
   localparam int TOCNT_LSB = 12;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [15:0] FRAME_RESET = 16'h0000;
   localparam logic [2:0] TOCNT_MAX = 3'h7;
endpackage : usbpes_pkg

// ==== verilog/usbpes_sync.sv ====
//=============================================================
// Purpose: two-flop synchroniser for pin levels
// Assumes: input is a slow level, not a pulse
// Notes:   resets to zero
//=============================================================
`timescale 1ns/1ns
module usbpes_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : usbpes_sync

// ==== verilog/usbpes_top.sv ====
//=============================================================
// Purpose: status flags and frame number registers, two device instances
// Assumes: event inputs are one-cycle pulses from same-clock engine logic
// Notes:   read data appear one cycle after reg_rd; writes act at once
//=============================================================
`timescale 1ns/1ns
module usbpes_top
   import usbpes_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic otg_id_pin,
   input wire logic id_int_en,
   input wire logic [1:0] full_speed,
   input wire logic [1:0] sof_eop_rcvd,
   input wire logic [1:0][FRAME_W-1:0] sof_frame,
   input wire logic [1:0] sof_timeout,
   input wire logic [1:0] timeout_int_en,
   input wire logic [1:0] bus_reset_det,
   input wire logic [1:0][NUM_EP-1:0] ep_done,
   input wire logic [1:0][NUM_EP-1:0] ep_nak,
   input wire logic [1:0][NUM_EP-1:0] nak_int_en
);
   //=============================================================
   // reset release
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   //=============================================================
   // OTG ID pin edge detection
   logic id_sync;
   logic id_prev;
   logic [2:0] id_arm;
   logic id_primed;
   logic next_id_prev;
   logic [2:0] next_id_arm;
   logic id_edge;

   usbpes_sync #(.W(1)) u_id_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d(otg_id_pin),
      .q(id_sync)
   );

   // arm only once the synchroniser and id_prev both hold the real pin level,
   // so a pin sitting high at reset release never looks like an edge
   always_comb begin
      next_id_prev = id_sync;
      next_id_arm = {id_arm[1:0], 1'h1};
      id_primed = id_arm[2];
      id_edge = id_primed && (id_sync != id_prev);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         id_prev <= 1'b0;
         id_arm <= 3'h0;
      end else begin
         id_prev <= next_id_prev;
         id_arm <= next_id_arm;
      end
   end

   //=============================================================
   // per-instance status and frame registers
   logic [1:0][15:0] status;
   logic [1:0][15:0] next_status;
   logic [1:0][15:0] frame;
   logic [1:0][15:0] next_frame;

   for (genvar d = 0; d < NUM_DEV; d++) begin : g_dev
      logic [15:0] set_bits;
      logic [15:0] clr_bits;
      logic [2:0] tocnt;

      assign tocnt = frame[d][TOCNT_LSB+2:TOCNT_LSB];

      always_comb begin
         set_bits = '0;
         clr_bits = '0;
         if (reg_wr && reg_addr == ADDR_STATUS[d]) begin
            clr_bits = reg_wdata;
         end
         set_bits[NUM_EP-1:0] = ep_done[d] | (ep_nak[d] & nak_int_en[d]);
         set_bits[BIT_SOF] = sof_eop_rcvd[d];
         set_bits[BIT_RST] = bus_reset_det[d];
         if (d == 0) begin
            set_bits[BIT_ID] = id_edge && id_int_en;
         end
         // set wins over a clear landing in the same cycle
         next_status[d] = (status[d] & ~clr_bits) | set_bits;
      end

      // frame register ignores the bus entirely, so writes cannot touch it
      always_comb begin
         next_frame[d] = frame[d];
         if (sof_eop_rcvd[d]) begin
            next_frame[d][TOCNT_LSB+2:TOCNT_LSB] = 3'h0;
            next_frame[d][BIT_TO_FLAG] = 1'b0;
            if (full_speed[d]) begin
               next_frame[d][FRAME_W-1:0] = sof_frame[d];
            end
         end else if (sof_timeout[d] && timeout_int_en[d]) begin
            next_frame[d][BIT_TO_FLAG] = 1'b1;
            if (tocnt != TOCNT_MAX) begin
               next_frame[d][TOCNT_LSB+2:TOCNT_LSB] = tocnt + 3'h1;
            end
         end
      end

      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            status[d] <= STATUS_RESET;
            frame[d] <= FRAME_RESET;
         end else begin
            status[d] <= next_status[d];
            frame[d] <= next_frame[d];
         end
      end

      //=============================================================
      // checks
      chk_ep_done_flag: assert property (@(posedge clk) disable iff (!rst_n)
         (|ep_done[d]) |=> ((status[d][7:0] & $past(ep_done[d])) == $past(ep_done[d])))
         else $error("endpoint done did not set its flag");
      chk_nak_gating: assert property (@(posedge clk) disable iff (!rst_n)
         (|(ep_nak[d] & ~nak_int_en[d] & ~ep_done[d] & ~status[d][7:0])
            && !(reg_wr && reg_addr == ADDR_STATUS[d]))
         |=> ((status[d][7:0]
            & $past(ep_nak[d] & ~nak_int_en[d] & ~ep_done[d] & ~status[d][7:0])) == 8'h00))
         else $error("masked nak set endpoint flag");
      chk_sof_flag: assert property (@(posedge clk) disable iff (!rst_n)
         sof_eop_rcvd[d] |=> status[d][BIT_SOF])
         else $error("sof event did not set flag");
      chk_reset_flag: assert property (@(posedge clk) disable iff (!rst_n)
         bus_reset_det[d] |=> status[d][BIT_RST])
         else $error("bus reset did not set flag");
      chk_w1c_clear: assert property (@(posedge clk) disable iff (!rst_n)
         (reg_wr && reg_addr == ADDR_STATUS[d] && reg_wdata[BIT_SOF] && !sof_eop_rcvd[d])
         |=> !status[d][BIT_SOF])
         else $error("write one did not clear flag");
      chk_write_zero: assert property (@(posedge clk) disable iff (!rst_n)
         (status[d][BIT_RST] && (!reg_wr || !reg_wdata[BIT_RST] || bus_reset_det[d]))
         |=> status[d][BIT_RST])
         else $error("flag lost without a clearing write");
      chk_frame_load: assert property (@(posedge clk) disable iff (!rst_n)
         (sof_eop_rcvd[d] && full_speed[d]) |=> frame[d][FRAME_W-1:0] == $past(sof_frame[d]))
         else $error("frame number not loaded");
      chk_frame_hold: assert property (@(posedge clk) disable iff (!rst_n)
         !sof_eop_rcvd[d] |=> $stable(frame[d][FRAME_W-1:0]))
         else $error("frame number changed without sof");
      chk_tocnt_step: assert property (@(posedge clk) disable iff (!rst_n)
         (sof_timeout[d] && timeout_int_en[d] && !sof_eop_rcvd[d] && tocnt != TOCNT_MAX)
         |=> tocnt == $past(tocnt) + 3'h1)
         else $error("timeout counter did not step");
      chk_tocnt_clear: assert property (@(posedge clk) disable iff (!rst_n)
         sof_eop_rcvd[d] |=> tocnt == 3'h0)
         else $error("timeout counter not cleared by sof");
      chk_read_status: assert property (@(posedge clk) disable iff (!rst_n)
         (reg_rd && reg_addr == ADDR_STATUS[d]) |=> reg_rdata == $past(status[d]))
         else $error("status read data wrong");
   end

   chk_id_edge_flag: assert property (@(posedge clk) disable iff (!rst_n)
      (id_primed && $changed(id_sync) && id_int_en) |=> status[0][BIT_ID])
      else $error("id pin edge did not set flag");
   chk_id_reserved: assert property (@(posedge clk) disable iff (!rst_n)
      status[1][15:10] == 6'h00)
      else $error("reserved bits set in second instance");

   //=============================================================
   // register read port
   logic [15:0] next_rdata;

   always_comb begin
      next_rdata = reg_rdata;
      if (reg_rd) begin
         // unmapped addresses read as zero
         next_rdata = 16'h0000;
         for (int d = 0; d < NUM_DEV; d++) begin
            if (reg_addr == ADDR_STATUS[d]) begin
               next_rdata = status[d];
            end
            if (reg_addr == ADDR_FRAME[d]) begin
               next_rdata = frame[d];
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= next_rdata;
      end
   end
endmodule : usbpes_top

// ==== tb/usbpes_host_model.sv ====
//=========================================
// Purpose: host-side event source for the status block
// Assumes: one event per go strobe, pulsed one edge later
// Notes: frame lines toggle while unqualified
//=========================================
`timescale 1ns/1ns
module usbpes_host_model
   import usbpes_pkg::*;
(
   input wire logic clk,
   input wire logic go,
   input wire logic [2:0] kind,
   input wire logic dev,
   input wire logic [10:0] arg,
   output logic [1:0] sof_eop_rcvd,
   output logic [1:0][FRAME_W-1:0] sof_frame,
   output logic [1:0] sof_timeout,
   output logic [1:0] bus_reset_det,
   output logic [1:0][NUM_EP-1:0] ep_done,
   output logic [1:0][NUM_EP-1:0] ep_nak
);
   initial begin
      {sof_eop_rcvd, sof_frame, sof_timeout, bus_reset_det, ep_done, ep_nak} = '0;
   end
   always @(posedge clk) begin
      {sof_eop_rcvd, sof_timeout, bus_reset_det, ep_done, ep_nak} <= '0;
      // stale frame must never look valid
      sof_frame <= ~sof_frame;
      if (go) begin
         case (kind)
            3'h0: ep_done[dev][arg[2:0]] <= 1'h1;
            3'h1: ep_nak[dev][arg[2:0]] <= 1'h1;
            3'h2: begin
               sof_eop_rcvd[dev] <= 1'h1;
               sof_frame[dev] <= arg;
            end
            3'h3: sof_timeout[dev] <= 1'h1;
            default: bus_reset_det[dev] <= 1'h1;
         endcase
      end
   end
endmodule : usbpes_host_model

// ==== tb/tb.sv ====
//=========================================
// Purpose: register-level test of the status block
// Assumes: read data valid one cycle after reg_rd
// Notes: all waits are fixed counts
//=========================================
`timescale 1ns/1ns
module tb import usbpes_pkg::*;;
   logic clk, resetn, reg_wr, reg_rd, otg_id_pin, id_int_en, go, dev;
   logic [15:0] reg_addr, reg_wdata, reg_rdata;
   logic [1:0] full_speed, timeout_int_en, sof_eop_rcvd, sof_timeout, bus_reset_det;
   logic [1:0][FRAME_W-1:0] sof_frame;
   logic [1:0][NUM_EP-1:0] ep_done, ep_nak, nak_int_en;
   logic [2:0] kind;
   logic [10:0] arg;
   int failures = 0;
   int total_checks = 0;
   usbpes_top usbpes_top_inst (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .otg_id_pin, .id_int_en, .full_speed, .sof_eop_rcvd, .sof_frame,
      .sof_timeout, .timeout_int_en, .bus_reset_det, .ep_done, .ep_nak, .nak_int_en);
   usbpes_host_model usbpes_host_model_inst (.clk, .go, .kind, .dev, .arg, .sof_eop_rcvd,
      .sof_frame, .sof_timeout, .bus_reset_det, .ep_done, .ep_nak);
   //=========================================
   // access tasks
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
      @(posedge clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'h0;
      @(negedge clk);
      cmp(reg_rdata, exp);
   endtask : rdc
   task automatic wr(input logic [15:0] a, input logic [15:0] v);
      @(posedge clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask : wr
   // clr lands a clearing write on the same edge as the event
   task automatic ev(input logic [2:0] k, input logic d, input logic [10:0] a,
      input logic clr);
      @(posedge clk);
      go <= 1'h1;
      kind <= k;
      dev <= d;
      arg <= a;
      @(posedge clk);
      go <= 1'h0;
      reg_wr <= clr;
      reg_addr <= ADDR_STATUS[d];
      reg_wdata <= 16'h0001 << a[2:0];
      // the clearing write stands only for the edge that also takes the event
      @(posedge clk);
      reg_wr <= 1'h0;
      @(posedge clk);
   endtask : ev
   task automatic conclude();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : conclude
   //=========================================
   // sequence
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   initial begin
      {resetn, reg_wr, reg_rd, otg_id_pin, id_int_en, go, dev, kind, arg} = '0;
      {reg_addr, reg_wdata, nak_int_en} = '0;
      full_speed = 2'h1;
      timeout_int_en = 2'h1;
      repeat (16) @(posedge clk);
      resetn <= 1'h1;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 2; i++) begin
         rdc(ADDR_STATUS[i], 16'h0000);
         rdc(ADDR_FRAME[i], 16'h0000);
      end
      rdc(16'hC094, 16'h0000);
      for (int i = 0; i < 16; i++) begin
         ev(3'h0, i[3], 11'(i % 8), 1'h0);
         rdc(ADDR_STATUS[i[3]], 16'h0001 << (i % 8));
         wr(ADDR_STATUS[i[3]], 16'h0000);
         rdc(ADDR_STATUS[i[3]], 16'h0001 << (i % 8));
         wr(ADDR_STATUS[i[3]], 16'h0001 << (i % 8));
         rdc(ADDR_STATUS[i[3]], 16'h0000);
      end
      ev(3'h1, 1'h1, 11'h002, 1'h0);
      rdc(ADDR_STATUS[1], 16'h0000);
      @(posedge clk);
      nak_int_en[1][2] <= 1'h1;
      ev(3'h1, 1'h1, 11'h002, 1'h0);
      rdc(ADDR_STATUS[1], 16'h0004);
      ev(3'h0, 1'h1, 11'h002, 1'h1);
      rdc(ADDR_STATUS[1], 16'h0004);
      ev(3'h4, 1'h1, 11'h000, 1'h0);
      rdc(ADDR_STATUS[1], 16'h0104);
      wr(ADDR_STATUS[1], 16'h0104);
      ev(3'h2, 1'h1, 11'h0FF, 1'h0);
      rdc(ADDR_FRAME[1], 16'h0000);
      rdc(ADDR_STATUS[1], 16'h0200);
      ev(3'h2, 1'h0, 11'h5A5, 1'h0);
      rdc(ADDR_FRAME[0], 16'h05A5);
      for (int i = 1; i < 9; i++) begin
         ev(3'h3, 1'h0, 11'h000, 1'h0);
         rdc(ADDR_FRAME[0], 16'h85A5 | (16'((i > 7) ? 7 : i) << 12));
      end
      wr(ADDR_FRAME[0], 16'h0000);
      rdc(ADDR_FRAME[0], 16'hF5A5);
      ev(3'h2, 1'h0, 11'h123, 1'h0);
      rdc(ADDR_FRAME[0], 16'h0123);
      ev(3'h3, 1'h1, 11'h000, 1'h0);
      rdc(ADDR_FRAME[1], 16'h0000);
      @(posedge clk);
      id_int_en <= 1'h1;
      otg_id_pin <= 1'h1;
      repeat (5) @(posedge clk);
      rdc(ADDR_STATUS[0], 16'h4200);
      rdc(ADDR_STATUS[1], 16'h0200);
      wr(ADDR_STATUS[0], 16'h4200);
      otg_id_pin <= 1'h0;
      repeat (5) @(posedge clk);
      rdc(ADDR_STATUS[0], 16'h4000);
      conclude();
   end
endmodule : tb
